// ==== design/display_latch_mem.sv ====
/*
  Display latch: one row of segment bits per common phase.
  Assumes a synchronous active-high reset and one write per cycle.
*/
module display_latch_mem #(
  parameter int WIDTH = 40,
  parameter int ROWS = 4,
  parameter int AW = 2
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_srst,
  // Write port
  input wire logic i_wr_en,
  input wire logic [AW-1:0] i_wr_addr,
  input wire logic [WIDTH-1:0] i_wr_data,
  // Read port, data registered
  input wire logic [AW-1:0] i_rd_addr,
  output logic [WIDTH-1:0] o_rd_data
);

  logic [WIDTH-1:0] rows [ROWS];

  // Row storage, cleared to all segments off at reset
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      for (int r = 0; r < ROWS; r++) begin
        rows[r] <= '0;
      end
    end else if (i_wr_en && (int'(i_wr_addr) < ROWS)) begin
      rows[i_wr_addr] <= i_wr_data;
    end
  end

  // Registered read
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_rd_data <= '0;
    end else if (int'(i_rd_addr) < ROWS) begin
      o_rd_data <= rows[i_rd_addr];
    end else begin
      o_rd_data <= '0;
    end
  end

endmodule

// ==== design/lcd_mux_pkg.sv ====
/*
  Constants and types shared by the multiplexed segment LCD driver.
  Assumes a single 50 MHz clock domain and APB register access.
*/
package lcd_mux_pkg;

  // ----------------------------------------------------------------
  // Display geometry and timing
  // ----------------------------------------------------------------
  localparam int SEG_COUNT = 40;
  localparam int COM_COUNT = 4;
  localparam int ROWS_QUARTER = 4;
  localparam int ROWS_THIRD = 3;
  localparam int FRAME_DIV = 24;
  localparam int SLOT_TICKS_QUARTER = FRAME_DIV / ROWS_QUARTER;
  localparam int SLOT_TICKS_THIRD = FRAME_DIV / ROWS_THIRD;
  localparam int CLK_HZ = 50_000_000;
  localparam int RC_FREQ_HZ = 2_000;
  localparam int RC_DIV_CYCLES = CLK_HZ / RC_FREQ_HZ;

  // ----------------------------------------------------------------
  // Serial word layout
  // ----------------------------------------------------------------
  localparam int SHIFT_LEN = 48;
  localparam int DATA_LSB = 0;
  localparam int ROW_LSB = 40;
  localparam int ROW_W = 2;
  localparam int CMD_BIT = 42;
  localparam int CMD_W = 8;
  localparam int CMD_BLANK_BIT = 0;

  // ----------------------------------------------------------------
  // APB register map
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] LAST_CMD_OFS = 8'h08;
  localparam logic [7:0] XFER_CNT_OFS = 8'h0C;
  localparam int CTRL_BLANK_BIT = 0;
  localparam int CTRL_FREEZE_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;
  localparam logic [CMD_W-1:0] CMD_RESET = 8'h00;

  // Serial pins from the host, raw and unsynchronised
  typedef struct packed {
    logic shift_clk;
    logic data;
    logic strobe;
  } serial_in_t;

  // Oscillator source
  typedef enum logic {
    SRC_INTERNAL_RC,
    SRC_EXTERNAL
  } osc_src_t;

endpackage

// ==== design/segment_lcd_multiplex_driver.sv ====
/*
  Multiplexed segment LCD driver logic: serial shift-in of segment
  data, display latch, frame timebase and common/segment scanning,
  with an APB slave for control and status.
  Assumes all pin inputs are asynchronous to i_clk; the analog drive
  levels and bias network sit outside this block.
*/

// Functional notes
// - Duty select pin high gives 1/3 duty, low gives 1/4 duty.
// - Quarter duty drives 4 rows of 40, 160 segments total.
// - Third duty drives 3 rows of 40, 120 segments total.
// - Forty segment outputs, multiplexed over the active common slots.
// - Frame rate is the selected timebase divided by 24.
// - A high data bit lights its segment, a low bit blanks it.
// - Data bit shifts in on each rising edge of shift clock.
// - Strobe moves shifted word to the latch or takes a command.
// - Source select low uses internal RC, high uses external pin.
// - Internal oscillator stays disabled while source select is high.
// - Active-low reset pin initialises all internal state except the input synchronisers.
// - In third duty only commons 1 to 3 scan; common 4 idles.
// - In quarter duty all four commons each get a slot.
module segment_lcd_multiplex_driver #(
  parameter int SHIFT_LEN = lcd_mux_pkg::SHIFT_LEN,
  parameter bit MSB_FIRST = 1'b1,
  parameter int CMD_BIT = lcd_mux_pkg::CMD_BIT,
  parameter int RC_DIV = lcd_mux_pkg::RC_DIV_CYCLES
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_reset_n,
  // Serial host interface and strap pins
  input wire lcd_mux_pkg::serial_in_t i_serial,
  input wire logic i_duty_select,
  input wire logic i_osc_source_select,
  input wire logic i_rc_timebase_pin,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // LCD drive
  output logic [lcd_mux_pkg::SEG_COUNT-1:0] o_segment_outputs,
  output logic o_common_drive_1,
  output logic o_common_drive_2,
  output logic o_common_drive_3,
  output logic o_common_drive_4,
  output logic o_frame_polarity,
  output logic o_osc_enable
);

  localparam int SEGS = lcd_mux_pkg::SEG_COUNT;
  localparam int RW = lcd_mux_pkg::ROW_W;
  localparam int CW = lcd_mux_pkg::CMD_W;
  localparam int CNT_W = $clog2(SHIFT_LEN + 1);
  localparam int DIV_W = $clog2(RC_DIV + 1);
  localparam logic [CNT_W-1:0] CNT_MAX = CNT_W'(SHIFT_LEN);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(RC_DIV - 1);
  localparam logic [3:0] SLOT_Q = 4'(lcd_mux_pkg::SLOT_TICKS_QUARTER);
  localparam logic [3:0] SLOT_T = 4'(lcd_mux_pkg::SLOT_TICKS_THIRD);
  localparam logic [1:0] LAST_ROW_Q = 2'(lcd_mux_pkg::ROWS_QUARTER - 1);
  localparam logic [1:0] LAST_ROW_T = 2'(lcd_mux_pkg::ROWS_THIRD - 1);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [5:0] sync_a;
  logic [5:0] sync_b;
  logic shift_prev;
  logic strobe_prev;
  logic ext_prev;

  // Two flip-flops on every pin input
  always_ff @(posedge i_clk) begin
    sync_a <= {i_serial.shift_clk, i_serial.data, i_serial.strobe,
               i_duty_select, i_osc_source_select, i_rc_timebase_pin};
    sync_b <= sync_a;
  end

  wire shift_s = sync_b[5];
  wire data_s = sync_b[4];
  wire strobe_s = sync_b[3];
  wire duty_third = sync_b[2];
  wire osc_sel_s = sync_b[1];
  wire ext_clk_s = sync_b[0];

  // Device reset pin, passed through two flip-flops before use
  wire rst_pin;
  logic reset_n_a;
  logic reset_n_b;
  always_ff @(posedge i_clk) begin
    reset_n_a <= i_reset_n;
    reset_n_b <= reset_n_a;
  end
  assign rst_pin = ~reset_n_b;

  // Combined reset: bus reset or the active-low reset pin
  wire rst = i_srst | rst_pin;

  // Edge history for the synchronised pins
  // Pins idle low, so the zero reset value gives no false edge
  always_ff @(posedge i_clk) begin
    if (rst) begin
      shift_prev <= 1'b0;
      strobe_prev <= 1'b0;
      ext_prev <= 1'b0;
    end else begin
      shift_prev <= shift_s;
      strobe_prev <= strobe_s;
      ext_prev <= ext_clk_s;
    end
  end

  wire shift_rise = shift_s & ~shift_prev;
  wire strobe_rise = strobe_s & ~strobe_prev;
  wire ext_rise = ext_clk_s & ~ext_prev;

  // ----------------------------------------------------------------
  // Serial shift register
  // ----------------------------------------------------------------
  logic [SHIFT_LEN-1:0] shift_word;
  logic [CNT_W-1:0] bit_count;
  wire [SHIFT_LEN-1:0] next_shift_word = MSB_FIRST ?
    {shift_word[SHIFT_LEN-2:0], data_s} :
    {data_s, shift_word[SHIFT_LEN-1:1]};

  // Shift one bit per rising shift clock; strobe restarts the count
  always_ff @(posedge i_clk) begin
    if (rst) begin
      shift_word <= '0;
      bit_count <= '0;
    end else if (shift_rise) begin
      shift_word <= next_shift_word;
      bit_count <= (bit_count == CNT_MAX) ? CNT_MAX : bit_count + 1'b1;
    end else if (strobe_rise) begin
      bit_count <= '0;
    end
  end

  // ----------------------------------------------------------------
  // Strobe decode: display row or command
  // ----------------------------------------------------------------
  logic [31:0] ctrl;
  wire freeze = ctrl[lcd_mux_pkg::CTRL_FREEZE_BIT];
  wire is_cmd = shift_word[CMD_BIT];
  wire row_write = strobe_rise & ~is_cmd & ~freeze;
  wire cmd_write = strobe_rise & is_cmd;
  wire [RW-1:0] wr_row = shift_word[lcd_mux_pkg::ROW_LSB +: RW];
  wire [SEGS-1:0] wr_data = shift_word[lcd_mux_pkg::DATA_LSB +: SEGS];
  logic [CW-1:0] last_cmd;
  logic [15:0] xfer_count;

  // Command latch and transfer counter
  always_ff @(posedge i_clk) begin
    if (rst) begin
      last_cmd <= lcd_mux_pkg::CMD_RESET;
      xfer_count <= 16'h0000;
    end else begin
      if (cmd_write) begin
        last_cmd <= shift_word[CW-1:0];
      end
      if (row_write) begin
        xfer_count <= xfer_count + 16'h0001;
      end
    end
  end

  // ----------------------------------------------------------------
  // Timebase and frame divider
  // ----------------------------------------------------------------
  logic [DIV_W-1:0] rc_count;
  wire rc_run = ~osc_sel_s;
  wire rc_tick = rc_run & (rc_count == DIV_LAST);
  wire tick = osc_sel_s ? ext_rise : rc_tick;

  // Internal RC model, held stopped when the external clock is used
  always_ff @(posedge i_clk) begin
    if (rst || !rc_run || rc_tick) begin
      rc_count <= '0;
    end else begin
      rc_count <= rc_count + 1'b1;
    end
  end

  logic [3:0] slot_tick;
  logic [1:0] slot;
  wire [3:0] slot_len = duty_third ? SLOT_T : SLOT_Q;
  wire [1:0] last_row = duty_third ? LAST_ROW_T : LAST_ROW_Q;
  wire slot_end = tick & (slot_tick == slot_len - 4'h1);
  wire frame_end = slot_end & (slot >= last_row);

  // Slots of 24/rows ticks each give 24 ticks per frame
  // A switch to third duty while in slot 3 ends the frame at the end of that slot through the >= test
  always_ff @(posedge i_clk) begin
    if (rst) begin
      slot_tick <= 4'h0;
      slot <= 2'h0;
      o_frame_polarity <= 1'b0;
    end else if (tick) begin
      slot_tick <= slot_end ? 4'h0 : slot_tick + 4'h1;
      if (frame_end) begin
        slot <= 2'h0;
        o_frame_polarity <= ~o_frame_polarity;
      end else if (slot_end) begin
        slot <= slot + 2'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Display latch and output drive
  // ----------------------------------------------------------------
  logic [SEGS-1:0] row_data;

  display_latch_mem #(
    .WIDTH(SEGS),
    .ROWS(lcd_mux_pkg::ROWS_QUARTER),
    .AW(RW)
  ) u_latch (
    .i_clk(i_clk),
    .i_srst(rst),
    .i_wr_en(row_write),
    .i_wr_addr(wr_row),
    .i_wr_data(wr_data),
    .i_rd_addr(slot),
    .o_rd_data(row_data)
  );

  wire blank = ctrl[lcd_mux_pkg::CTRL_BLANK_BIT] |
               last_cmd[lcd_mux_pkg::CMD_BLANK_BIT];
  logic [1:0] shown_slot;
  logic [3:0] common_one_hot;

  // Segments follow the row of the slot; high bit lights a segment
  // Commons lag the slot by two stages to line up with the read data
  always_ff @(posedge i_clk) begin
    if (rst) begin
      o_segment_outputs <= '0;
      shown_slot <= 2'h0;
      common_one_hot <= 4'h0;
    end else begin
      o_segment_outputs <= blank ? '0 : row_data;
      shown_slot <= slot;
      common_one_hot <= 4'h1 << shown_slot;
      if (duty_third) begin
        common_one_hot[3] <= 1'b0;
      end
    end
  end

  // Common lines and oscillator enable
  assign o_common_drive_1 = common_one_hot[0];
  assign o_common_drive_2 = common_one_hot[1];
  assign o_common_drive_3 = common_one_hot[2];
  assign o_common_drive_4 = common_one_hot[3];
  assign o_osc_enable = rc_run;

  // ----------------------------------------------------------------
  // APB slave, zero wait states
  // ----------------------------------------------------------------
  wire acc = psel & penable;
  wire hit_ctrl = (paddr == lcd_mux_pkg::CTRL_OFS);
  wire hit_stat = (paddr == lcd_mux_pkg::STATUS_OFS);
  wire hit_cmd = (paddr == lcd_mux_pkg::LAST_CMD_OFS);
  wire hit_cnt = (paddr == lcd_mux_pkg::XFER_CNT_OFS);
  wire mapped = hit_ctrl | hit_stat | hit_cmd | hit_cnt;
  // Status: shifted bit count, polarity, slot, source and duty
  wire [31:0] status_word = {18'h0, 8'(bit_count), 1'b0,
    o_frame_polarity, slot, osc_sel_s, duty_third};
  wire [31:0] rd_mux = hit_ctrl ? ctrl :
                       hit_stat ? status_word :
                       hit_cmd ? {24'h000000, last_cmd} :
                       hit_cnt ? {16'h0000, xfer_count} : 32'h00000000;

  // No wait states: every access completes in its first access cycle
  assign pready = 1'b1;
  assign pslverr = acc & ~mapped;

  // Control register write and registered read data
  // Read data is captured in setup so it stands through the access
  always_ff @(posedge i_clk) begin
    if (rst) begin
      ctrl <= {30'h00000000, lcd_mux_pkg::CTRL_RESET};
      prdata <= 32'h00000000;
    end else begin
      if (acc && pwrite && hit_ctrl) begin
        ctrl <= {30'h00000000, pwdata[1:0]};
      end
      if (psel && !penable && !pwrite) begin
        prdata <= rd_mux;
      end
    end
  end

endmodule

// ==== design/unused_placeholder_none.sv ====
/*
  Intentionally empty compilation unit.
  Assumes nothing.
*/

// ==== tb/lcd_drv_monitor.sv ====
/*
  Checker for the LCD driver top module, attached by bind.
  Assumes the internal timebase divides i_clk by RC_DIV.
*/
module lcd_drv_monitor #(
  parameter int RC_DIV = 2
) (
  // Clock, resets and pins
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_reset_n,
  input wire lcd_mux_pkg::serial_in_t i_serial,
  input wire logic i_duty_select,
  input wire logic i_osc_source_select,
  // Drive outputs
  input wire logic [lcd_mux_pkg::SEG_COUNT-1:0] o_segment_outputs,
  input wire logic o_common_drive_1,
  input wire logic o_common_drive_2,
  input wire logic o_common_drive_3,
  input wire logic o_common_drive_4,
  input wire logic o_frame_polarity,
  input wire logic o_osc_enable
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_srst || !i_reset_n);

  // ----------------------------------------------------------------
  // Helper state
  // ----------------------------------------------------------------
  wire [3:0] com = {o_common_drive_4, o_common_drive_3,
    o_common_drive_2, o_common_drive_1};
  logic [3:0] com_d1, com_d2, com_d3;
  logic [3:0] strobe_age = 4'hF;
  logic [15:0] gap;
  logic pol_d, frames_ok;

  // Delayed commons, strobe age and cycles between polarity flips
  always_ff @(posedge i_clk) begin
    com_d1 <= com;
    com_d2 <= com_d1;
    com_d3 <= com_d2;
    pol_d <= o_frame_polarity;
    gap <= (o_frame_polarity != pol_d) ? 16'h1 : gap + 16'h1;
    strobe_age <= i_serial.strobe ? 4'h0 :
      strobe_age + {3'h0, strobe_age != 4'hF};
    if (i_srst || !i_reset_n || i_osc_source_select ||
        !o_osc_enable) begin
      frames_ok <= 1'h0;
    end else if (o_frame_polarity != pol_d) begin
      frames_ok <= 1'h1;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  AST_ONE_COMMON: assert property ($onehot0(com))
    else $error("more than one common active");
  AST_THIRD_NO_COMMON_DRIVE_4: assert property (
    i_duty_select [*8] |-> !o_common_drive_4)
    else $error("common 4 driven in third duty");
  AST_EXT_OSC_OFF: assert property (
    i_osc_source_select [*6] |-> !o_osc_enable)
    else $error("oscillator running with external source");
  AST_RC_OSC_ON: assert property (
    !i_osc_source_select [*6] |-> o_osc_enable)
    else $error("oscillator stopped with internal source");
  AST_SRST_CLEARS: assert property (disable iff (1'h0)
    i_srst |=> o_segment_outputs == '0 && com == 4'h0)
    else $error("outputs not cleared by reset");
  AST_PIN_RESET: assert property (disable iff (i_srst)
    !i_reset_n [*4] |=> o_segment_outputs == '0 && com == 4'h0)
    else $error("outputs not cleared by reset pin");
  AST_SEG_HOLD: assert property (
    !$stable(o_segment_outputs) |-> com != com_d3 || strobe_age < 4'h8)
    else $error("segments changed mid slot");
  AST_FRAME_LEN: assert property (
    frames_ok && o_frame_polarity != pol_d |-> gap == 16'(24 * RC_DIV))
    else $error("frame length wrong");

  // Main scenarios reached
  CVR_STROBE: cover property (i_serial.strobe);
  CVR_THIRD: cover property (i_duty_select && o_common_drive_3);
  CVR_FRAME: cover property (frames_ok && o_frame_polarity != pol_d);
endmodule

bind segment_lcd_multiplex_driver lcd_drv_monitor #(.RC_DIV(RC_DIV)) mon (
  .i_clk, .i_srst, .i_reset_n, .i_serial, .i_duty_select,
  .i_osc_source_select, .o_segment_outputs, .o_common_drive_1,
  .o_common_drive_2, .o_common_drive_3, .o_common_drive_4,
  .o_frame_polarity, .o_osc_enable);

// ==== tb/lcd_host_model.sv ====
/*
  Host model: shifts words into the LCD driver over the three serial pins.
  Assumes one 50 MHz clock; each pin level is held at least three clock cycles.
*/
module lcd_host_model (
  // Clock
  input wire logic i_clk,
  // Serial pins towards the driver
  output lcd_mux_pkg::serial_in_t o_serial
);
  timeunit 1ns;
  timeprecision 1ns;

  initial o_serial = 3'h0;

  // Wait a number of rising edges
  task automatic hold(input int n);
    repeat (n) @(posedge i_clk);
  endtask

  // Shift one word, first bit lands at the top, then pulse the strobe
  task automatic send(input logic [47:0] w);
    @(posedge i_clk);
    for (int i = 47; i >= 0; i--) begin
      o_serial.data <= w[i];
      hold(3);
      o_serial.shift_clk <= 1'h1;
      hold(3);
      o_serial.shift_clk <= 1'h0;
      hold(3);
    end
    o_serial.strobe <= 1'h1;
    hold(3);
    o_serial.strobe <= 1'h0;
    o_serial.data <= ~w[0];
    hold(4);
  endtask
endmodule

// ==== tb/tb_top.sv ====
/*
  Self-checking bench for the LCD driver: APB tasks and serial words.
  Assumes the host model drives the serial pins; RC_DIV is set to 2.
*/
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic i_clk, i_srst, i_reset_n, duty, osc, rc, ext_run, er;
  logic psel, penable, pwrite, pready, pslverr, c1, c2, c3, c4, osc_en;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [39:0] seg;
  logic [3:0] m;
  logic [39:0] pat [4];
  lcd_mux_pkg::serial_in_t ser;
  wire [3:0] com = {c4, c3, c2, c1};
  int fail_count = 0;
  int n_tests = 0;

  // Clock and gated external timebase
  always #10 i_clk = ~i_clk;
  always @(posedge i_clk) if (ext_run) rc <= ~rc;

  segment_lcd_multiplex_driver #(.RC_DIV(2)) uut (
    .i_clk, .i_srst, .i_reset_n, .i_serial(ser), .i_duty_select(duty),
    .i_osc_source_select(osc), .i_rc_timebase_pin(rc), .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .o_segment_outputs(seg), .o_common_drive_1(c1), .o_common_drive_2(c2),
    .o_common_drive_3(c3), .o_common_drive_4(c4), .o_frame_polarity(),
    .o_osc_enable(osc_en));
  lcd_host_model host (.i_clk, .o_serial(ser));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic summarize();
    if (fail_count == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // A bound that ran out ends the run
  task automatic tmo(input int n);
    if (n >= 400) begin
      fail_count++;
      summarize();
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
  endtask

  // One APB transfer; read data and error land in rd and er
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int k;
    @(posedge i_clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge i_clk);
    penable <= 1'h1;
    for (k = 0; k == 0 || (pready !== 1'h1 && k < 400); k++) begin
      @(posedge i_clk);
    end
    tmo(k);
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic put(input logic c, input logic [1:0] r,
                     input logic [39:0] d);
    host.send({5'h00, c, r, d});
  endtask

  // Wait for a fresh slot of common k, then compare its segments
  task automatic look(input int k, input logic [39:0] exp);
    int n;
    for (n = 0; com[k] === 1'h1 && n < 400; n++) @(negedge i_clk);
    tmo(n);
    for (n = 0; com[k] !== 1'h1 && n < 400; n++) @(negedge i_clk);
    tmo(n);
    repeat (4) @(negedge i_clk);
    chk(seg, exp);
  endtask

  task automatic scan();
    m = 4'h0;
    repeat (300) begin
      @(negedge i_clk);
      m = m | com;
    end
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {i_clk, i_srst, i_reset_n, duty, osc, rc, ext_run} = 7'h30;
    {psel, penable, pwrite, paddr, pwdata} = 43'h0;
    pat = '{40'h8000000001, 40'hFFFFFFFFFF, 40'hAAAAAAAAAA, 40'h0123456789};
    tick(16);
    i_srst <= 1'h0;
    tick(4);
    look(0, 40'h0);
    for (int r = 0; r < 4; r++) put(1'h0, r[1:0], pat[r]);
    for (int r = 0; r < 4; r++) look(r, pat[r]);
    scan();
    chk(m, 4'hF);
    apb(1'h0, 8'h0C, 32'h0);
    chk(rd, 32'h4);
    apb(1'h0, 8'h04, 32'h0);
    chk({rd[13:6], rd[0]}, 9'h0);
    put(1'h1, 2'h0, 40'hA5);
    apb(1'h0, 8'h08, 32'h0);
    chk(rd, 32'hA5);
    look(1, 40'h0);
    put(1'h1, 2'h0, 40'h5A);
    look(1, pat[1]);
    apb(1'h0, 8'h0C, 32'h0);
    chk(rd, 32'h4);
    apb(1'h1, 8'h00, 32'h2);
    apb(1'h0, 8'h00, 32'h0);
    chk(rd, 32'h2);
    put(1'h0, 2'h0, 40'h1);
    look(0, pat[0]);
    apb(1'h1, 8'h00, 32'h0);
    apb(1'h1, 8'h10, 32'h3);
    chk(er, 1'h1);
    apb(1'h0, 8'h10, 32'h0);
    chk({er, rd}, 33'h100000000);
    put(1'h0, 2'h0, 40'hC30000003C);
    look(0, 40'hC30000003C);
    osc <= 1'h1;
    tick(10);
    chk(osc_en, 1'h0);
    apb(1'h0, 8'h04, 32'h0);
    chk(rd[1], 1'h1);
    scan();
    chk($countones(m), 1);
    ext_run <= 1'h1;
    scan();
    chk(m, 4'hF);
    tick(1);
    osc <= 1'h0;
    tick(10);
    chk(osc_en, 1'h1);
    duty <= 1'h1;
    i_srst <= 1'h1;
    tick(2);
    i_srst <= 1'h0;
    tick(4);
    apb(1'h0, 8'h04, 32'h0);
    chk(rd[0], 1'h1);
    put(1'h0, 2'h2, pat[2]);
    look(2, pat[2]);
    scan();
    chk(m, 4'h7);
    tick(1);
    i_reset_n <= 1'h0;
    tick(6);
    chk(seg, 40'h0);
    i_reset_n <= 1'h1;
    tick(6);
    apb(1'h0, 8'h0C, 32'h0);
    chk(rd, 32'h0);
    look(2, 40'h0);
    summarize();
  end
endmodule
